// File: logic/sem_map.svh
// Offsets, field positions, reset values for the socket event block.
// Assumes inclusion by bare name from the design file only.
`ifndef SEM_MAP_SVH
`define SEM_MAP_SVH

// ----------------------------------------------------------------
// Register offsets within one socket window
// ----------------------------------------------------------------
`define SEM_OFS_FLAGS      6'h00
`define SEM_OFS_ENABLES    6'h04
`define SEM_OFS_CONDITION  6'h08
`define SEM_OFS_INJECT     6'h0c
`define SEM_OFS_CONTROL    6'h10
`define SEM_OFS_POWER      6'h20

// ----------------------------------------------------------------
// Window geometry
// ----------------------------------------------------------------
`define SEM_WIN_LSB        12
`define SEM_OFS_MSB        5

// ----------------------------------------------------------------
// Flag and enable bit positions
// ----------------------------------------------------------------
`define SEM_BIT_PWR        3
`define SEM_BIT_CD2        2
`define SEM_BIT_CD1        1
`define SEM_BIT_CSTS       0
`define SEM_CD_IRQ_ON      2'h3

// ----------------------------------------------------------------
// Other fields
// ----------------------------------------------------------------
`define SEM_BIT_PME_EN     8
`define SEM_BIT_CBCARD     5
`define SEM_CONTROL_MASK   32'h0000_00ff
`define SEM_POWER_MASK     32'h0000_0100

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SEM_FLAGS_RST      4'h0
`define SEM_ENABLES_RST    4'h0
`define SEM_CONTROL_RST    32'h0000_0000
`define SEM_POWER_RST      32'h0000_0000

`endif

// File: logic/sem_pkg.sv
// Types shared by the socket event block.
// Assumes nothing of its surroundings.
package sem_pkg;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef logic [31:0] sem_word_t;
	typedef logic [3:0]  sem_flags_t;
	typedef logic [5:0]  sem_offset_t;

endpackage : sem_pkg

// File: logic/sem_socket_event.sv
// Socket event flags, enables and status-change interrupt, two sockets.
// Assumes a single-cycle memory request port already steered to this
// block, window bases from each function's base register, and card
// pins that are asynchronous to CLK.
`timescale 1ns/100ps

`include "sem_map.svh"

// Functional notes
// - Socket registers decoded at fixed window offsets.
// - Each function has its own window base.
// - Flags record change only; state read elsewhere.
// - Write one clears flag, zero keeps it.
// - Inject write sets matching flag.
// - Bus reset clears all flags unless PME is enabled.
// - Leaving card reset re-sets present status and detect events.
// - Set and enabled flag raises interrupt.
// - Power cycle change sets flag bit three.
// - Detect two change sets flag bit two.
// - Detect one change sets flag bit one.
// - 32-bit card: status rising edge only.
// - 16-bit card: status both edges.
// - Upper bits read zero, ignore writes.
// - PME enabled: only global reset clears context.
// - Enables never stop flags from setting.
// - Enable bit three gates power cycle.
// - Detect enable active only at 11.
// - Enable bit zero gates card status.
module sem_socket_event
(
	input  wire logic              CLK,
	input  wire logic              ARST_N,
	input  wire logic              BUS_RESET_N,
	input  wire sem_pkg::sem_word_t SOCK_BASE_0,
	input  wire sem_pkg::sem_word_t SOCK_BASE_1,
	input  wire logic              MEM_REQ,
	input  wire logic              MEM_WE,
	input  wire logic [3:0]        MEM_BE,
	input  wire sem_pkg::sem_word_t MEM_ADDR,
	input  wire sem_pkg::sem_word_t MEM_WDATA,
	output logic                   MEM_HIT,
	output logic                   MEM_ACK,
	output sem_pkg::sem_word_t     MEM_RDATA,
	input  wire logic [1:0]        POWER_CYCLE_STATE,
	input  wire logic [1:0]        CARD_DETECT_ONE_STATE,
	input  wire logic [1:0]        CARD_DETECT_TWO_STATE,
	input  wire logic [1:0]        CARD_STATUS_STATE,
	input  wire logic [1:0]        CARD_IS_32BIT,
	input  wire logic [1:0]        CARD_RESET_N,
	output logic [1:0]             STATUS_CHANGE_INTERRUPT
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic win_hit
	(
		input sem_pkg::sem_word_t addr,
		input sem_pkg::sem_word_t base
	);
		win_hit = (addr[31:`SEM_WIN_LSB] == base[31:`SEM_WIN_LSB]);
	endfunction : win_hit

	function automatic logic irq_gate
	(
		input sem_pkg::sem_flags_t flags,
		input sem_pkg::sem_flags_t en
	);
		logic cd_on;
		cd_on = (en[`SEM_BIT_CD2:`SEM_BIT_CD1] == `SEM_CD_IRQ_ON);
		irq_gate = (flags[`SEM_BIT_PWR] & en[`SEM_BIT_PWR])
			| (flags[`SEM_BIT_CSTS] & en[`SEM_BIT_CSTS])
			| ((flags[`SEM_BIT_CD2] | flags[`SEM_BIT_CD1]) & cd_on);
	endfunction : irq_gate

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [1:0]          bus_rst_sync_reg;
	logic                bus_rst_act;
	logic [1:0]          pwr_s1_reg;
	logic [1:0]          pwr_s2_reg;
	logic [1:0]          pwr_old_reg;
	logic [1:0]          cd1_s1_reg;
	logic [1:0]          cd1_s2_reg;
	logic [1:0]          cd1_old_reg;
	logic [1:0]          cd2_s1_reg;
	logic [1:0]          cd2_s2_reg;
	logic [1:0]          cd2_old_reg;
	logic [1:0]          sts_s1_reg;
	logic [1:0]          sts_s2_reg;
	logic [1:0]          sts_old_reg;
	logic [1:0]          wide_s1_reg;
	logic [1:0]          wide_s2_reg;
	logic [1:0]          crst_s1_reg;
	logic [1:0]          crst_s2_reg;
	logic [1:0]          crst_old_reg;
	sem_pkg::sem_flags_t flags_reg [2];
	sem_pkg::sem_flags_t flags_next [2];
	sem_pkg::sem_flags_t enables_reg [2];
	sem_pkg::sem_word_t  control_reg [2];
	sem_pkg::sem_word_t  power_reg [2];
	sem_pkg::sem_flags_t hw_set [2];
	logic [1:0]          pme_on;
	logic [1:0]          ctx_clear;
	logic                hit_a;
	logic                hit_b;
	logic                sel;
	sem_pkg::sem_offset_t ofs;
	logic                wr_lo;
	logic [1:0]          wr_flags;
	logic [1:0]          wr_enables;
	logic [1:0]          wr_inject;
	logic [1:0]          wr_control;
	logic [1:0]          wr_power;
	sem_pkg::sem_word_t  rd_word;
	sem_pkg::sem_word_t  be_mask;

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	// Bus reset is a pin, so it is synchronised before it clears state
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			bus_rst_sync_reg <= 2'h0;
		end
		else
		begin
			bus_rst_sync_reg <= {bus_rst_sync_reg[0], BUS_RESET_N};
		end
	end

	assign bus_rst_act = ~bus_rst_sync_reg[1];

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			pwr_s1_reg  <= 2'h0;
			pwr_s2_reg  <= 2'h0;
			cd1_s1_reg  <= 2'h0;
			cd1_s2_reg  <= 2'h0;
			cd2_s1_reg  <= 2'h0;
			cd2_s2_reg  <= 2'h0;
			sts_s1_reg  <= 2'h0;
			sts_s2_reg  <= 2'h0;
			wide_s1_reg <= 2'h0;
			wide_s2_reg <= 2'h0;
			// Card reset idles high; a low reset value would fake a release
			crst_s1_reg <= 2'h3;
			crst_s2_reg <= 2'h3;
		end
		else
		begin
			pwr_s1_reg  <= POWER_CYCLE_STATE;
			pwr_s2_reg  <= pwr_s1_reg;
			cd1_s1_reg  <= CARD_DETECT_ONE_STATE;
			cd1_s2_reg  <= cd1_s1_reg;
			cd2_s1_reg  <= CARD_DETECT_TWO_STATE;
			cd2_s2_reg  <= cd2_s1_reg;
			sts_s1_reg  <= CARD_STATUS_STATE;
			sts_s2_reg  <= sts_s1_reg;
			wide_s1_reg <= CARD_IS_32BIT;
			wide_s2_reg <= wide_s1_reg;
			crst_s1_reg <= CARD_RESET_N;
			crst_s2_reg <= crst_s1_reg;
		end
	end

	// ----------------------------------------------------------------
	// Change detection
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			pwr_old_reg  <= 2'h0;
			cd1_old_reg  <= 2'h0;
			cd2_old_reg  <= 2'h0;
			sts_old_reg  <= 2'h0;
			crst_old_reg <= 2'h3;
		end
		else
		begin
			pwr_old_reg  <= pwr_s2_reg;
			cd1_old_reg  <= cd1_s2_reg;
			cd2_old_reg  <= cd2_s2_reg;
			sts_old_reg  <= sts_s2_reg;
			crst_old_reg <= crst_s2_reg;
		end
	end

	// Flags only note that something moved; the level stays readable
	// in the condition register
	always_comb
	begin
		for (int s = 0; s < 2; s++)
		begin
			hw_set[s] = 4'h0;
			hw_set[s][`SEM_BIT_PWR] = pwr_s2_reg[s] ^ pwr_old_reg[s];
			hw_set[s][`SEM_BIT_CD2] = cd2_s2_reg[s] ^ cd2_old_reg[s];
			hw_set[s][`SEM_BIT_CD1] = cd1_s2_reg[s] ^ cd1_old_reg[s];
			if (wide_s2_reg[s])
			begin
				hw_set[s][`SEM_BIT_CSTS] = sts_s2_reg[s] & ~sts_old_reg[s];
			end
			else
			begin
				hw_set[s][`SEM_BIT_CSTS] = sts_s2_reg[s] ^ sts_old_reg[s];
			end
			// Status and detects still present when the card leaves reset
			if (crst_s2_reg[s] & ~crst_old_reg[s])
			begin
				hw_set[s][`SEM_BIT_CSTS] = hw_set[s][`SEM_BIT_CSTS]
					| sts_s2_reg[s];
				hw_set[s][`SEM_BIT_CD1] = hw_set[s][`SEM_BIT_CD1]
					| cd1_s2_reg[s];
				hw_set[s][`SEM_BIT_CD2] = hw_set[s][`SEM_BIT_CD2]
					| cd2_s2_reg[s];
			end
		end
	end

	// ----------------------------------------------------------------
	// Window decode
	// ----------------------------------------------------------------
	assign hit_a = win_hit(MEM_ADDR, SOCK_BASE_0);
	assign hit_b = win_hit(MEM_ADDR, SOCK_BASE_1) & ~hit_a;
	assign sel   = hit_b;
	assign ofs   = MEM_ADDR[`SEM_OFS_MSB:0];
	assign wr_lo = MEM_REQ & MEM_WE & MEM_BE[0];

	always_comb
	begin
		for (int s = 0; s < 2; s++)
		begin
			logic mine;
			mine = (s == 0) ? hit_a : hit_b;
			wr_flags[s]   = wr_lo & mine & (ofs == `SEM_OFS_FLAGS);
			wr_enables[s] = wr_lo & mine & (ofs == `SEM_OFS_ENABLES);
			wr_inject[s]  = wr_lo & mine & (ofs == `SEM_OFS_INJECT);
			wr_control[s] = MEM_REQ & MEM_WE & mine
				& (ofs == `SEM_OFS_CONTROL);
			wr_power[s]   = MEM_REQ & MEM_WE & mine
				& (ofs == `SEM_OFS_POWER);
		end
	end

	assign be_mask = {{8{MEM_BE[3]}}, {8{MEM_BE[2]}},
		{8{MEM_BE[1]}}, {8{MEM_BE[0]}}};

	// ----------------------------------------------------------------
	// Event flags
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int s = 0; s < 2; s++)
		begin
			flags_next[s] = flags_reg[s];
			if (wr_flags[s])
			begin
				flags_next[s] = flags_next[s] & ~MEM_WDATA[3:0];
			end
			// Setting after clearing: an event in the clear cycle survives
			flags_next[s] = flags_next[s] | hw_set[s];
			if (wr_inject[s])
			begin
				flags_next[s] = flags_next[s] | MEM_WDATA[3:0];
			end
		end
	end

	always_comb
	begin
		for (int s = 0; s < 2; s++)
		begin
			pme_on[s]    = power_reg[s][`SEM_BIT_PME_EN];
			ctx_clear[s] = bus_rst_act & ~pme_on[s];
		end
	end

	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			flags_reg[0] <= `SEM_FLAGS_RST;
			flags_reg[1] <= `SEM_FLAGS_RST;
		end
		else
		begin
			for (int s = 0; s < 2; s++)
			begin
				if (ctx_clear[s])
				begin
					flags_reg[s] <= `SEM_FLAGS_RST;
				end
				else
				begin
					flags_reg[s] <= flags_next[s];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Enables, control, power management
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			enables_reg[0] <= `SEM_ENABLES_RST;
			enables_reg[1] <= `SEM_ENABLES_RST;
		end
		else
		begin
			for (int s = 0; s < 2; s++)
			begin
				if (ctx_clear[s])
				begin
					enables_reg[s] <= `SEM_ENABLES_RST;
				end
				else if (wr_enables[s])
				begin
					enables_reg[s] <= MEM_WDATA[3:0];
				end
			end
		end
	end

	// Control keeps only its low byte here; its fields are decoded elsewhere
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			control_reg[0] <= `SEM_CONTROL_RST;
			control_reg[1] <= `SEM_CONTROL_RST;
		end
		else
		begin
			for (int s = 0; s < 2; s++)
			begin
				if (ctx_clear[s])
				begin
					control_reg[s] <= `SEM_CONTROL_RST;
				end
				else if (wr_control[s])
				begin
					control_reg[s] <= ((MEM_WDATA & be_mask)
						| (control_reg[s] & ~be_mask)) & `SEM_CONTROL_MASK;
				end
			end
		end
	end

	// Only the global reset clears this, or PME enable would be lost
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			power_reg[0] <= `SEM_POWER_RST;
			power_reg[1] <= `SEM_POWER_RST;
		end
		else
		begin
			for (int s = 0; s < 2; s++)
			begin
				if (wr_power[s])
				begin
					power_reg[s] <= ((MEM_WDATA & be_mask)
						| (power_reg[s] & ~be_mask)) & `SEM_POWER_MASK;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			STATUS_CHANGE_INTERRUPT <= 2'h0;
		end
		else
		begin
			for (int s = 0; s < 2; s++)
			begin
				STATUS_CHANGE_INTERRUPT[s] <=
					irq_gate(flags_reg[s], enables_reg[s]);
			end
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_comb
	begin
		rd_word = 32'h0000_0000;
		unique case (ofs)
			`SEM_OFS_FLAGS:
			begin
				rd_word[3:0] = flags_reg[sel];
			end
			`SEM_OFS_ENABLES:
			begin
				rd_word[3:0] = enables_reg[sel];
			end
			`SEM_OFS_CONDITION:
			begin
				rd_word[`SEM_BIT_PWR]    = pwr_s2_reg[sel];
				rd_word[`SEM_BIT_CD2]    = cd2_s2_reg[sel];
				rd_word[`SEM_BIT_CD1]    = cd1_s2_reg[sel];
				rd_word[`SEM_BIT_CSTS]   = sts_s2_reg[sel];
				rd_word[`SEM_BIT_CBCARD] = wide_s2_reg[sel];
			end
			`SEM_OFS_CONTROL:
			begin
				rd_word = control_reg[sel];
			end
			`SEM_OFS_POWER:
			begin
				rd_word = power_reg[sel];
			end
			default:
			begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	// Answer one cycle after the request; unmapped offsets read zero
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			MEM_ACK   <= 1'b0;
			MEM_RDATA <= 32'h0000_0000;
		end
		else
		begin
			MEM_ACK <= MEM_REQ & (hit_a | hit_b);
			if (MEM_REQ & ~MEM_WE & (hit_a | hit_b))
			begin
				MEM_RDATA <= rd_word;
			end
		end
	end

	assign MEM_HIT = hit_a | hit_b;

endmodule : sem_socket_event

// File: test/sem_socket_event_props.sv
// Checker for the socket event block: bus timing and read-backs.
// Assumes binding onto sem_socket_event; one clock domain.
`timescale 1ns/100ps
module sem_socket_event_props
(
	input wire logic               CLK,
	input wire logic               ARST_N,
	input wire sem_pkg::sem_word_t SOCK_BASE_0,
	input wire sem_pkg::sem_word_t SOCK_BASE_1,
	input wire logic               MEM_REQ,
	input wire logic               MEM_WE,
	input wire sem_pkg::sem_word_t MEM_ADDR,
	input wire logic               MEM_HIT,
	input wire logic               MEM_ACK,
	input wire sem_pkg::sem_word_t MEM_RDATA,
	input wire logic [1:0]         STATUS_CHANGE_INTERRUPT
);
	// --------
	// Helpers
	// --------
	logic       rd_hit;
	logic [5:0] ofs;
	assign rd_hit = MEM_REQ && MEM_HIT && !MEM_WE;
	assign ofs = MEM_ADDR[5:0];
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	// --------
	// Properties
	// --------
	AST_HIT_DECODE: assert property (
		MEM_HIT == (MEM_ADDR[31:12] == SOCK_BASE_0[31:12] ||
		MEM_ADDR[31:12] == SOCK_BASE_1[31:12]))
		else $error("window decode wrong");
	AST_ACK_AFTER_HIT: assert property (
		MEM_REQ && MEM_HIT |=> MEM_ACK) else $error("ack missing");
	AST_NO_STRAY_ACK: assert property (
		!(MEM_REQ && MEM_HIT) |=> !MEM_ACK) else $error("stray ack");
	AST_RDATA_HOLD: assert property (
		!rd_hit |=> $stable(MEM_RDATA)) else $error("read data moved");
	AST_FLAGS_UPPER: assert property (
		rd_hit && ofs == 6'h00 |=> MEM_RDATA[31:4] == 28'h0)
		else $error("flag upper bits set");
	AST_EN_UPPER: assert property (
		rd_hit && ofs == 6'h04 |=> MEM_RDATA[31:4] == 28'h0)
		else $error("enable upper bits set");
	AST_INJECT_READ: assert property (
		rd_hit && ofs == 6'h0c |-> ##1 MEM_RDATA == 32'h0)
		else $error("inject reads nonzero");
	AST_RSVD_READ: assert property (
		rd_hit && ofs inside {6'h14, 6'h18, 6'h1c} |-> ##1
		MEM_ACK && MEM_RDATA == 32'h0) else $error("reserved nonzero");

	CVR_READ: cover property (rd_hit);
	CVR_WRITE: cover property (MEM_REQ && MEM_HIT && MEM_WE);
	CVR_IRQ: cover property ($rose(STATUS_CHANGE_INTERRUPT[0]));
endmodule : sem_socket_event_props

bind sem_socket_event sem_socket_event_props u_props (.CLK, .ARST_N,
	.SOCK_BASE_0, .SOCK_BASE_1, .MEM_REQ, .MEM_WE, .MEM_ADDR, .MEM_HIT,
	.MEM_ACK, .MEM_RDATA, .STATUS_CHANGE_INTERRUPT);

// File: test/testbench.sv
// Self-checking bench for the socket event block.
// Assumes the design package and module are compiled first.
`timescale 1ns/100ps
module testbench;
	logic               CLK, ARST_N, BUS_RESET_N, MEM_REQ, MEM_WE;
	logic               MEM_HIT, MEM_ACK;
	logic [3:0]         MEM_BE;
	sem_pkg::sem_word_t SOCK_BASE_0, SOCK_BASE_1, MEM_ADDR, MEM_WDATA;
	sem_pkg::sem_word_t MEM_RDATA, rd;
	logic [1:0]         POWER_CYCLE_STATE, CARD_DETECT_ONE_STATE;
	logic [1:0]         CARD_DETECT_TWO_STATE, CARD_STATUS_STATE;
	logic [1:0]         CARD_IS_32BIT, CARD_RESET_N;
	logic [1:0]         STATUS_CHANGE_INTERRUPT;
	logic [3:0]         f;
	int                 fail_count, cmp_count;
	localparam logic [5:0] hole_ofs [5] =
		'{6'h0c, 6'h14, 6'h18, 6'h1c, 6'h24};

	sem_socket_event dut (.CLK, .ARST_N, .BUS_RESET_N, .SOCK_BASE_0,
		.SOCK_BASE_1, .MEM_REQ, .MEM_WE, .MEM_BE, .MEM_ADDR, .MEM_WDATA,
		.MEM_HIT, .MEM_ACK, .MEM_RDATA, .POWER_CYCLE_STATE,
		.CARD_DETECT_ONE_STATE, .CARD_DETECT_TWO_STATE, .CARD_STATUS_STATE,
		.CARD_IS_32BIT, .CARD_RESET_N, .STATUS_CHANGE_INTERRUPT);

	// --------
	// Tasks
	// --------
	task automatic print_verdict;
		if (fail_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input sem_pkg::sem_word_t e, g);
		cmp_count++;
		if (g !== e)
		begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask : chk

	task automatic wt(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask : wt

	// Strobe is one cycle; ack and data land at the next edge
	task automatic acc(input bit s, input logic [5:0] o, input logic w,
		input sem_pkg::sem_word_t d);
		MEM_REQ = 1'b1;
		MEM_WE = w;
		MEM_ADDR = (s ? SOCK_BASE_1 : SOCK_BASE_0) | {26'h0, o};
		MEM_WDATA = d;
		wt(1);
		MEM_REQ = 1'b0;
		chk("ack", 32'h1, {31'h0, MEM_ACK});
		rd = MEM_RDATA;
		// Idle edge so the strobe never drops and rises in one step
		wt(1);
	endtask : acc

	task automatic wr(input bit s, input logic [5:0] o,
		input sem_pkg::sem_word_t d);
		acc(s, o, 1'b1, d);
	endtask : wr

	task automatic rdc(input bit s, input logic [5:0] o,
		input sem_pkg::sem_word_t e, input string nm);
		acc(s, o, 1'b0, 32'h0);
		chk(nm, e, rd);
	endtask : rdc

	function automatic logic exp_irq(input logic [3:0] fl, en);
		return (fl[3] & en[3]) | (fl[0] & en[0]) |
			((|fl[2:1]) & (en[2:1] == 2'h3));
	endfunction : exp_irq

	// --------
	// Clock and watchdog
	// --------
	initial
	begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end

	initial
	begin
		#400000;
		fail_count++;
		print_verdict();
	end

	// --------
	// Main sequence
	// --------
	initial
	begin
		{ARST_N, MEM_REQ, MEM_WE} = 3'h0;
		BUS_RESET_N = 1'b1;
		MEM_BE = 4'hf;
		SOCK_BASE_0 = 32'h1000_0000;
		SOCK_BASE_1 = 32'h2000_0000;
		MEM_ADDR = 32'h0;
		MEM_WDATA = 32'h0;
		{POWER_CYCLE_STATE, CARD_DETECT_ONE_STATE} = 4'h0;
		{CARD_DETECT_TWO_STATE, CARD_STATUS_STATE} = 4'h0;
		CARD_IS_32BIT = 2'h3;
		CARD_RESET_N = 2'h3;
		void'($urandom(35));
		repeat (5) @(posedge CLK);
		#1;
		ARST_N = 1'b1;
		wt(4);
		for (int s = 0; s < 2; s++)
		begin
			rdc(s[0], 6'h00, 32'h0, "flags");
			rdc(s[0], 6'h04, 32'h0, "enables");
			wr(s[0], 6'h04, '1);
			rdc(s[0], 6'h04, 32'hf, "enables");
			for (int b = 0; b < 4; b++)
			begin
				wr(s[0], 6'h0c, 32'h1 << b);
				rdc(s[0], 6'h00, 32'h1 << b, "inject");
				wr(s[0], 6'h00, 32'hf ^ (32'h1 << b));
				rdc(s[0], 6'h00, 32'h1 << b, "w0keep");
				wr(s[0], 6'h00, 32'h1 << b);
				rdc(s[0], 6'h00, 32'h0, "w1clr");
			end
			for (int e = 0; e < 16; e++)
			begin
				f = 4'($urandom);
				wr(s[0], 6'h00, '1);
				wr(s[0], 6'h04, 32'h0);
				wr(s[0], 6'h0c, {28'h0, f});
				rdc(s[0], 6'h00, {28'h0, f}, "masked");
				wr(s[0], 6'h04, e);
				wt(2);
				chk("irq", {31'h0, exp_irq(f, 4'(e))},
					{31'h0, STATUS_CHANGE_INTERRUPT[s]});
			end
			wr(s[0], 6'h00, '1);
			wr(s[0], 6'h04, 32'h0);
			for (int k = 0; k < 6; k++)
			begin
				case (k % 3)
					0: POWER_CYCLE_STATE[s] = ~POWER_CYCLE_STATE[s];
					1: CARD_DETECT_ONE_STATE[s] = ~CARD_DETECT_ONE_STATE[s];
					default: CARD_DETECT_TWO_STATE[s] = ~CARD_DETECT_TWO_STATE[s];
				endcase
				wt(5);
				rdc(s[0], 6'h00, (k % 3 == 0) ? 32'h8 : (k % 3 == 1) ? 32'h2 : 32'h4, "pin");
				wr(s[0], 6'h00, '1);
			end
			for (int m = 0; m < 2; m++)
			begin
				CARD_IS_32BIT[s] = m[0];
				wt(3);
				for (int v = 1; v >= 0; v--)
				begin
					CARD_STATUS_STATE[s] = v[0];
					wt(5);
					rdc(s[0], 6'h00, (m == 1 && v == 0) ? 32'h0 : 32'h1, "sts");
					wr(s[0], 6'h00, '1);
				end
			end
			// Card held in reset with status and detects present
			CARD_RESET_N[s] = 1'b0;
			CARD_STATUS_STATE[s] = 1'b1;
			CARD_DETECT_ONE_STATE[s] = 1'b1;
			CARD_DETECT_TWO_STATE[s] = 1'b1;
			wt(6);
			wr(s[0], 6'h00, '1);
			CARD_RESET_N[s] = 1'b1;
			wt(6);
			rdc(s[0], 6'h00, 32'h7, "rearm");
			rdc(s[0], 6'h08, 32'h27, "state");
			{CARD_STATUS_STATE[s], CARD_DETECT_ONE_STATE[s]} = 2'h0;
			CARD_DETECT_TWO_STATE[s] = 1'b0;
			wt(6);
			wr(s[0], 6'h00, '1);
		end
		wr(1'b1, 6'h0c, 32'h1);
		rdc(1'b0, 6'h00, 32'h0, "other");
		rdc(1'b1, 6'h00, 32'h1, "own");
		foreach (hole_ofs[i])
			rdc(1'b1, hole_ofs[i], 32'h0, "rsvd");
		MEM_ADDR = 32'h3000_0000;
		MEM_REQ = 1'b1;
		wt(1);
		MEM_REQ = 1'b0;
		chk("miss", 32'h0, {31'h0, MEM_ACK});
		for (int p = 0; p < 2; p++)
		begin
			wr(1'b0, 6'h20, p << 8);
			wr(1'b0, 6'h0c, 32'h5);
			wr(1'b0, 6'h04, 32'h3);
			BUS_RESET_N = 1'b0;
			wt(6);
			BUS_RESET_N = 1'b1;
			wt(3);
			rdc(1'b0, 6'h00, p ? 32'h5 : 32'h0, "busrst");
			rdc(1'b0, 6'h04, p ? 32'h3 : 32'h0, "busrst");
			rdc(1'b0, 6'h20, p << 8, "pme");
		end
		ARST_N = 1'b0;
		wt(2);
		ARST_N = 1'b1;
		wt(4);
		rdc(1'b0, 6'h00, 32'h0, "global_reset_n");
		rdc(1'b0, 6'h04, 32'h0, "global_reset_n");
		rdc(1'b0, 6'h20, 32'h0, "global_reset_n");
		print_verdict();
	end
endmodule : testbench
